// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb;
  import irq_enable_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  reg_req_t    i_req = '0;
  logic [31:0] i_event = '0;
  logic [31:0] o_rdata;
  logic        o_irq;
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          bits[8] = '{30, 6, 5, 4, 3, 2, 1, 0};

  irq_enable_mask DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_event(i_event), .o_rdata(o_rdata), .o_irq(o_irq));

  always #50 i_clock = ~i_clock;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge i_clock);
    i_req <= '{1'b1, wr, a, d};
    @(posedge i_clock);
    i_req <= '0;
    repeat (3) @(posedge i_clock);
    #1;
  endtask

  task automatic pulse(input int b);
    @(posedge i_clock);
    i_event <= 32'h1 << b;
    @(posedge i_clock);
    i_event <= '0;
    repeat (3) @(posedge i_clock);
    #1;
  endtask

  task automatic test_reset();
    access(1'b0, ENABLE_OFFSET, '0);
    check(o_rdata, 32'h0000_0000);
    check({31'h0, o_irq}, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_set_clear();
    access(1'b1, ENABLE_OFFSET, 32'h8000_0004);
    access(1'b1, ENABLE_OFFSET, 32'h0000_0001);
    access(1'b0, ENABLE_OFFSET, '0);
    check(o_rdata, 32'h8000_0005);
    access(1'b0, ENABLE_OFFSET, '0);
    check(o_rdata, 32'h8000_0005);
    access(1'b0, DISABLE_OFFSET, '0);
    check(o_rdata, 32'h8000_0005);
    access(1'b0, 8'h00, '0);
    check(o_rdata, 32'h0000_0000);
    access(1'b1, ENABLE_OFFSET, 32'hc000_007f);
    access(1'b0, ENABLE_OFFSET, '0);
    check(o_rdata, 32'hc000_007f);
    access(1'b1, DISABLE_OFFSET, 32'h4000_0001);
    access(1'b0, ENABLE_OFFSET, '0);
    check(o_rdata, 32'h8000_007e);
    access(1'b1, DISABLE_OFFSET, 32'hc000_007f);
    access(1'b0, ENABLE_OFFSET, '0);
    check(o_rdata, 32'h0000_0000);
    $display("test_set_clear done");
  endtask

  // Event with its enable clear, then enable it, then clear the status
  task automatic test_each_event();
    foreach (bits[i]) begin
      access(1'b1, ENABLE_OFFSET, 32'h8000_0000);
      pulse(bits[i]);
      check({31'h0, o_irq}, 32'h0);
      access(1'b0, STATUS_OFFSET, '0);
      check(o_rdata, 32'h1 << bits[i]);
      access(1'b1, ENABLE_OFFSET, 32'h1 << bits[i]);
      check({31'h0, o_irq}, 32'h1);
      access(1'b1, STATUS_OFFSET, 32'h1 << bits[i]);
      check({31'h0, o_irq}, 32'h0);
      access(1'b1, DISABLE_OFFSET, 32'hc000_007f);
    end
    $display("test_each_event done");
  endtask

  task automatic test_master();
    access(1'b1, ENABLE_OFFSET, 32'h0000_007f);
    pulse(5);
    check({31'h0, o_irq}, 32'h0);
    access(1'b1, ENABLE_OFFSET, 32'h8000_0000);
    check({31'h0, o_irq}, 32'h1);
    access(1'b1, DISABLE_OFFSET, 32'h8000_0000);
    check({31'h0, o_irq}, 32'h0);
    access(1'b0, STATUS_OFFSET, '0);
    check(o_rdata, 32'h0000_0020);
    $display("test_master done");
  endtask

  initial begin
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    test_reset();
    test_set_clear();
    test_each_event();
    test_master();
    end_of_test();
  end
endmodule

// ==== rtl/irq_enable_mask.sv ====
`timescale 1ns/1ns
module irq_enable_mask
  import irq_enable_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire reg_req_t             i_req,
  input  wire logic [REG_WIDTH-1:0] i_event,
  output logic      [REG_WIDTH-1:0] o_rdata,
  output logic                      o_irq
);

  logic [REG_WIDTH-1:0] enable_reg;
  logic [REG_WIDTH-1:0] enable_next;
  logic [REG_WIDTH-1:0] status_reg;
  logic [REG_WIDTH-1:0] status_next;
  logic [REG_WIDTH-1:0] rdata_reg;
  logic [REG_WIDTH-1:0] rdata_next;
  logic                 irq_reg;
  logic                 irq_next;
  logic                 wr_enable;
  logic                 wr_disable;
  logic                 wr_status;
  logic                 pending;

  assign wr_enable  = i_req.valid && i_req.write
                      && (i_req.addr == ENABLE_OFFSET);
  assign wr_disable = i_req.valid && i_req.write
                      && (i_req.addr == DISABLE_OFFSET);
  assign wr_status  = i_req.valid && i_req.write
                      && (i_req.addr == STATUS_OFFSET);

  // Per-bit event enables; one generate covers every event position
  logic [REG_WIDTH-1:0] gated;
  genvar g;
  generate
    for (g = 0; g < REG_WIDTH; g++) begin : g_bit
      if (EVENT_IMPL_MASK[g]) begin : g_ev
        assign gated[g] = status_reg[g] & enable_reg[g];
      end else begin : g_none
        assign gated[g] = 1'b0;
      end
    end
  endgenerate

  // Bits 30, 6, 5, 4, 3, 2, 1, 0 each gate their own event
  assign pending = (|gated) & enable_reg[MASTER_BIT];

  always_comb begin
    enable_next = enable_reg;
    if (wr_enable) begin
      // Write one sets, zero keeps; reserved bits never store
      enable_next = enable_next
                    | (i_req.wdata & ENABLE_IMPL_MASK);
    end
    if (wr_disable) begin
      enable_next = enable_next & ~i_req.wdata;
    end
  end

  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_next & ~i_req.wdata;
    end
    // A new event wins over a same-cycle clear
    status_next = status_next | (i_event & EVENT_IMPL_MASK);
  end

  always_comb begin
    rdata_next = '0;
    if (i_req.valid && !i_req.write) begin
      unique case (i_req.addr)
        ENABLE_OFFSET:  rdata_next = enable_reg;
        DISABLE_OFFSET: rdata_next = enable_reg;
        STATUS_OFFSET:  rdata_next = status_reg;
        default:        rdata_next = '0;
      endcase
    end else begin
      rdata_next = rdata_reg;
    end
  end

  assign irq_next = pending;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_reg <= ENABLE_RESET;
      status_reg <= STATUS_RESET;
      rdata_reg  <= '0;
      irq_reg    <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      status_reg <= status_next;
      rdata_reg  <= rdata_next;
      irq_reg    <= irq_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq   = irq_reg;

  // Assertions
  default clocking cb @(posedge i_clock);
  endclocking

  default disable iff (!i_rst_n);

  // An enabled event with the master bit set
  sequence armed_s;
    enable_reg[MASTER_BIT]
      && ((status_reg & enable_reg & EVENT_IMPL_MASK) != '0);
  endsequence

  sequence irq_up_s;
    o_irq;
  endsequence

  sequence enable_rd_s;
    i_req.valid && !i_req.write && (i_req.addr == ENABLE_OFFSET);
  endsequence

  sequence disable_rd_s;
    i_req.valid && !i_req.write && (i_req.addr == DISABLE_OFFSET);
  endsequence

  sequence unmapped_rd_s;
    i_req.valid && !i_req.write && (i_req.addr != ENABLE_OFFSET)
      && (i_req.addr != DISABLE_OFFSET) && (i_req.addr != STATUS_OFFSET);
  endsequence

  irq_cause_a: assert property (
    o_irq == $past(pending))
    else $error("interrupt does not follow gated status");

  irq_follow_a: assert property (
    armed_s |=> irq_up_s)
    else $error("armed event did not raise the interrupt");

  irq_drop_a: assert property (
    !pending |=> !o_irq)
    else $error("interrupt raised with nothing pending");

  irq_master_a: assert property (
    !$past(enable_reg[MASTER_BIT]) |-> !o_irq)
    else $error("interrupt raised without master enable");

  enable_set_a: assert property (
    wr_enable && !wr_disable |=> ((enable_reg & $past(i_req.wdata)
      & ENABLE_IMPL_MASK) == ($past(i_req.wdata) & ENABLE_IMPL_MASK)))
    else $error("enable write did not set bits");

  enable_keep_a: assert property (
    !wr_disable |=> ((enable_reg & $past(enable_reg)) == $past(enable_reg)))
    else $error("enable bit cleared without disable");

  disable_clr_a: assert property (
    wr_disable |=> ((enable_reg & $past(i_req.wdata)) == '0))
    else $error("disable write did not clear bits");

  disable_read_a: assert property (
    disable_rd_s |=> o_rdata == $past(enable_reg))
    else $error("disable read did not return enables");

  read_back_a: assert property (
    enable_rd_s |=> o_rdata == $past(enable_reg) && $stable(enable_reg))
    else $error("enable read wrong or had a side effect");

  unmapped_read_a: assert property (
    unmapped_rd_s |=> o_rdata == '0)
    else $error("unmapped read returned data");

  rdata_hold_a: assert property (
    !(i_req.valid && !i_req.write) |=> $stable(o_rdata))
    else $error("read data changed without a read");

  reserved_zero_a: assert property (
    (enable_reg & ~ENABLE_IMPL_MASK) == '0)
    else $error("reserved enable bit stored");

  status_hold_a: assert property (
    !wr_status |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
    else $error("status bit cleared by hardware");

  status_clear_a: assert property (
    wr_status |=> ((status_reg & $past(i_req.wdata)
      & ~$past(i_event)) == '0))
    else $error("status write of one did not clear");

  status_set_a: assert property (
    ##1 ((status_reg & $past(i_event) & EVENT_IMPL_MASK)
      == ($past(i_event) & EVENT_IMPL_MASK)))
    else $error("event did not set its status bit");

  status_spare_a: assert property (
    (status_reg & ~EVENT_IMPL_MASK) == '0)
    else $error("unimplemented status bit set");

  event_wins_a: assert property (
    i_event[SOF_BIT] |=> status_reg[SOF_BIT])
    else $error("event lost against a clear");

  reset_off_a: assert property (
    $rose(i_rst_n) |-> enable_reg == ENABLE_RESET && !o_irq)
    else $error("enables not clear after reset");

  // Each implemented event reaches the interrupt through its own enable
  generate
    for (g = 0; g < REG_WIDTH; g++) begin : g_chk
      if (EVENT_IMPL_MASK[g]) begin : g_ev
        event_path_a: assert property (
          status_reg[g] && enable_reg[g] && enable_reg[MASTER_BIT]
          |=> o_irq)
          else $error("enabled event did not interrupt");
      end
    end
  endgenerate

endmodule

// ==== shared/irq_enable_pkg.sv ====
package irq_enable_pkg;

  localparam int unsigned REG_WIDTH = 32;
  localparam int unsigned ADDR_WIDTH = 8;

  // Register byte offsets
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] ENABLE_OFFSET = 8'h10;
  localparam logic [7:0] DISABLE_OFFSET = 8'h14;

  // Field positions
  localparam int unsigned MASTER_BIT = 31;
  localparam int unsigned OWNERSHIP_BIT = 30;
  localparam int unsigned ROOT_HUB_BIT = 6;
  localparam int unsigned FRAME_OVF_BIT = 5;
  localparam int unsigned FATAL_ERR_BIT = 4;
  localparam int unsigned RESUME_BIT = 3;
  localparam int unsigned SOF_BIT = 2;
  localparam int unsigned WRITEBACK_BIT = 1;
  localparam int unsigned OVERRUN_BIT = 0;

  // Implemented bits of the enable and status registers
  localparam logic [31:0] ENABLE_IMPL_MASK = 32'hc000_007f;
  localparam logic [31:0] EVENT_IMPL_MASK = 32'h4000_007f;

  // Reset values
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [ADDR_WIDTH-1:0] addr;
    logic [REG_WIDTH-1:0]  wdata;
  } reg_req_t;

endpackage
